// file: gcl_apb.sv
// Purpose: APB slave register file for the counter
// Assumes: APB3, zero wait states
// Notes:   unmapped addresses read zero and raise pslverr
`include "gcl_params.svh"
module gcl_apb
	import gcl_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] ctrl_r,
	output logic      [31:0] high_r,
	output logic      [31:0] low_r,
	output logic      [31:0] start_r,
	output logic      [31:0] dicfg_r,
	output logic             sync_clr,
	input  wire logic [31:0] status,
	input  wire logic [31:0] count,
	input  wire logic [31:0] capt
);
	logic [31:0] ctrl_nxt, high_nxt, low_nxt, start_nxt, dicfg_nxt;
	logic [31:0] rd;
	logic        hit;
	logic        wr;

	assign wr       = psel & penable & pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel & ~hit;
	assign prdata   = (psel & ~pwrite) ? rd : 32'h0000_0000;
	assign sync_clr = wr & (paddr == `GCL_OFS_CTRL)
		& pwdata[`GCL_CTL_SYNCCLR];

	always_comb begin
		hit = 1'b1;
		rd  = 32'h0000_0000;
		case (paddr)
		`GCL_OFS_CTRL:   rd = ctrl_r;
		`GCL_OFS_HIGH:   rd = high_r;
		`GCL_OFS_LOW:    rd = low_r;
		`GCL_OFS_START:  rd = start_r;
		`GCL_OFS_DICFG:  rd = dicfg_r;
		`GCL_OFS_STATUS: rd = status;
		`GCL_OFS_COUNT:  rd = count;
		`GCL_OFS_CAPT:   rd = capt;
		default:         hit = 1'b0;
		endcase
	end

	always_comb begin
		ctrl_nxt  = ctrl_r;
		high_nxt  = high_r;
		low_nxt   = low_r;
		start_nxt = start_r;
		dicfg_nxt = dicfg_r;
		if (wr) begin
			case (paddr)
			`GCL_OFS_CTRL:  ctrl_nxt = pwdata & 32'h0000_07FF;
			`GCL_OFS_HIGH:  high_nxt = pwdata;
			`GCL_OFS_LOW:   low_nxt = pwdata;
			`GCL_OFS_START: start_nxt = pwdata;
			`GCL_OFS_DICFG: dicfg_nxt = pwdata & 32'h003F_3F3F;
			default:        ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_r  <= `GCL_RST_CTRL;
			high_r  <= `GCL_RST_HIGH;
			low_r   <= `GCL_RST_LOW;
			start_r <= `GCL_RST_START;
			dicfg_r <= `GCL_RST_DICFG;
		end else begin
			ctrl_r  <= ctrl_nxt;
			high_r  <= high_nxt;
			low_r   <= low_nxt;
			start_r <= start_nxt;
			dicfg_r <= dicfg_nxt;
		end
	end
endmodule // gcl_apb

// file: gcl_counter.sv
// Purpose: gated 32-bit up/down encoder counter with limits and capture
// Assumes: A/B/N and DI pins asynchronous; APB on clock
// Notes:   config errors (limits, duplicate functions) flag in status
`include "gcl_params.svh"
module gcl_counter
	import gcl_pkg::*;
#(
	parameter int NUM_DI = 3
) (
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              enc_a,
	input  wire logic              enc_b,
	input  wire logic              enc_n,
	input  wire logic [NUM_DI-1:0] din,
	output logic signed [31:0]     count_r,
	output logic signed [31:0]     latched_count_value,
	output logic                   sync_occurred_flag,
	output logic [NUM_DI-1:0]      input_state_r
);
	if (NUM_DI < 1 || NUM_DI > 3) begin : g_chk
		$error("NUM_DI must be 1 to 3");
	end

	// ------------------------------------------------------------------
	// Registers and synchronisers
	// ------------------------------------------------------------------
	logic [31:0] ctrl_r, high_r, low_r, start_r, dicfg_r, status;
	logic        sync_clr;
	logic [NUM_DI+2:0] lvl, rs, fl;
	logic signed [31:0] hi, lo, st;
	logic [31:0] prdata_c;
	logic        pready_c, pslverr_c;

	gcl_apb u_apb (
		.clock    (clock),
		.reset    (reset),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.prdata   (prdata_c),
		.pready   (pready_c),
		.pslverr  (pslverr_c),
		.ctrl_r   (ctrl_r),
		.high_r   (high_r),
		.low_r    (low_r),
		.start_r  (start_r),
		.dicfg_r  (dicfg_r),
		.sync_clr (sync_clr),
		.status   (status),
		.count    (count_r),
		.capt     (latched_count_value)
	);
	// Registered bus outputs: decoded in setup, shown in access
	always_ff @(posedge clock) begin
		prdata  <= reset ? 32'h0000_0000 : prdata_c;
		pready  <= !reset && psel && !penable && pready_c;
		pslverr <= !reset && psel && !penable && pslverr_c;
	end

	gcl_sync #(.WIDTH(NUM_DI + 3)) u_sync (
		.clock (clock),
		.reset (reset),
		.pin   ({din, enc_n, enc_b, enc_a}),
		.level (lvl),
		.rise  (rs),
		.fall  (fl)
	);

	// signed view of the high limit, low limit and start value
	assign hi = signed'(high_r);
	assign lo = signed'(low_r);
	assign st = signed'(start_r);

	// ------------------------------------------------------------------
	// Control decode
	// ------------------------------------------------------------------
	gcl_eval_type   eval;
	gcl_nreact_type nreact;
	logic sw_gate, stop_v, rld_st, gstart_ld, sync_per, cap_once, cap_rld;
	assign sw_gate   = ctrl_r[`GCL_CTL_SWGATE];
	assign stop_v    = ctrl_r[`GCL_CTL_STOPV];
	assign rld_st    = ctrl_r[`GCL_CTL_RLDST];
	assign gstart_ld = ctrl_r[`GCL_CTL_GSTART];
	assign eval      = gcl_eval_type'(ctrl_r[`GCL_CTL_EVAL +: 2]);
	assign nreact    = gcl_nreact_type'(ctrl_r[`GCL_CTL_NREACT +: 2]);
	assign sync_per  = ctrl_r[`GCL_CTL_SYNCPER];
	assign cap_once  = ctrl_r[`GCL_CTL_CAPONCE];
	assign cap_rld   = ctrl_r[`GCL_CTL_CAPRLD];

	function automatic gcl_func_type di_func(input logic [31:0] c,
		input int i);
		di_func = gcl_func_type'(c[i*`GCL_DI_STRIDE +: 3]);
	endfunction

	// ------------------------------------------------------------------
	// Per-input functions
	// ------------------------------------------------------------------
	logic [NUM_DI-1:0] act, edg, is_lvl, is_gon, is_goff, is_sync;
	logic [NUM_DI-1:0] is_sen, is_cap;
	logic [3:0]        dup;
	for (genvar i = 0; i < NUM_DI; i++) begin : g_di
		logic [1:0] es;
		logic       lowact;
		assign es     = dicfg_r[i*`GCL_DI_STRIDE + 3 +: 2];
		assign lowact = dicfg_r[i*`GCL_DI_STRIDE + 5];
		assign act[i] = lvl[3+i] ^ lowact;
		assign edg[i] = (es == GCL_ED_RISE) ? rs[3+i] :
			(es == GCL_ED_FALL) ? fl[3+i] :
			(di_func(dicfg_r, i) == GCL_FN_CAPT) ? (rs[3+i] | fl[3+i])
			: rs[3+i];
		assign is_lvl[i]  = di_func(dicfg_r, i) == GCL_FN_LVLGATE;
		assign is_gon[i]  = di_func(dicfg_r, i) == GCL_FN_GSTART;
		assign is_goff[i] = di_func(dicfg_r, i) == GCL_FN_GSTOP;
		assign is_sync[i] = di_func(dicfg_r, i) == GCL_FN_SYNC;
		assign is_sen[i]  = di_func(dicfg_r, i) == GCL_FN_SYNCEN;
		assign is_cap[i]  = di_func(dicfg_r, i) == GCL_FN_CAPT;
	end

	// duplicate functions disable that function entirely; a duplicate gate start or stop disables both
	function automatic logic one_hot0(input logic [NUM_DI-1:0] v);
		one_hot0 = ($countones(v) <= 1);
	endfunction
	logic [6:0] uniq;
	assign uniq = {one_hot0(is_cap), one_hot0(is_sen), one_hot0(is_sync),
		one_hot0(is_goff), one_hot0(is_gon), one_hot0(is_lvl), 1'b1};
	assign dup = {3'h0, ~&uniq};

	logic lvl_used, edge_used, hw_lvl, g_on, g_off, sync_ev, sync_en;
	logic cap_ev, n_sync_ev, n_cap_ev;
	assign lvl_used  = |is_lvl & uniq[1];
	assign edge_used = (|is_gon | |is_goff) & uniq[2] & uniq[3];
	assign hw_lvl    = |(is_lvl & act);
	assign g_on      = |(is_gon & edg) & uniq[2];
	assign g_off     = |(is_goff & edg) & uniq[3];
	// reference-mark sync gated by enable input when assigned
	assign sync_en   = (|is_sen & uniq[5]) ? |(is_sen & act) : 1'b1;
	assign n_sync_ev = (nreact == GCL_N_SYNC) & rs[2] & sync_en;
	assign sync_ev   = (|(is_sync & edg) & uniq[4]) | n_sync_ev;
	// input and reference-mark capture may coexist
	assign n_cap_ev  = (nreact == GCL_N_CAPT) & rs[2];
	assign cap_ev    = (|(is_cap & edg) & uniq[6]) | n_cap_ev;

	// ------------------------------------------------------------------
	// Quadrature evaluation
	// ------------------------------------------------------------------
	logic a, b, ae, be, inc, dec;
	assign a  = lvl[0];
	assign b  = lvl[1];
	assign ae = rs[0] | fl[0];
	assign be = rs[1] | fl[1];
	always_comb begin
		inc = 1'b0;
		dec = 1'b0;
		case (eval)
		GCL_EV_SINGLE: begin
			inc = rs[0] & ~b;
			dec = fl[0] & ~b;
		end
		GCL_EV_DOUBLE: begin
			inc = ae & (a ^ b);
			dec = ae & ~(a ^ b);
		end
		GCL_EV_QUAD: begin
			inc = (ae & (a ^ b)) | (be & ~(a ^ b));
			dec = (ae & ~(a ^ b)) | (be & (a ^ b));
		end
		default: ;
		endcase
	end

	// ------------------------------------------------------------------
	// Gate state machine and counter
	// ------------------------------------------------------------------
	gcl_state_type st_r, st_nxt;
	logic hw_r, hw_nxt, ext_open;
	logic signed [31:0] count_nxt, cap_nxt, nx;
	logic sync_done_r, sync_done_nxt, cap_done_r, cap_done_nxt;
	logic sflag_nxt, viol;
	logic [NUM_DI-1:0] ist_nxt;

	always_comb begin
		hw_nxt = hw_r;
		if (g_on)
			hw_nxt = 1'b1;
		else if (g_off)
			hw_nxt = 1'b0;
	end
	// Gate follows the software gate alone when no gate function is assigned
	assign ext_open = sw_gate & (lvl_used ? hw_lvl :
		(edge_used ? hw_r : 1'b1));

	// count only with all gates open
	always_comb begin
		st_nxt        = st_r;
		count_nxt     = count_r;
		cap_nxt       = latched_count_value;
		sync_done_nxt = sync_done_r;
		cap_done_nxt  = cap_done_r;
		viol          = 1'b0;
		nx            = count_r;
		case (st_r)
		GCL_ST_CLOSED: begin
			if (ext_open) begin
				st_nxt = GCL_ST_OPEN;
				if (gstart_ld)
					count_nxt = st;
			end
		end
		GCL_ST_OPEN: begin
			if (!ext_open) begin
				st_nxt = GCL_ST_CLOSED;
			end else begin
				if (inc)
					nx = count_r + 32'sh1;
				else if (dec)
					nx = count_r - 32'sh1;
				viol = (inc && count_r >= hi) || (dec && count_r <= lo);
				if (viol) begin
					if (stop_v)
						st_nxt = GCL_ST_HALTED;
					else if (rld_st)
						count_nxt = st;
					else
						count_nxt = inc ? lo : hi;
				end else begin
					count_nxt = nx;
				end
			end
		end
		GCL_ST_HALTED: begin
			if (!ext_open)
				st_nxt = GCL_ST_CLOSED;
		end
		default: st_nxt = GCL_ST_CLOSED;
		endcase
		if (cap_ev && (!cap_once || !cap_done_r)) begin
			cap_nxt      = count_r;
			cap_done_nxt = 1'b1;
			if (cap_rld)
				count_nxt = st;
		end
		// sync once or periodic, wins over counting
		if (sync_ev && (sync_per || !sync_done_r)) begin
			count_nxt     = st;
			sync_done_nxt = 1'b1;
		end
	end

	// Set wins over software clear
	assign sflag_nxt = (sync_ev && (sync_per || !sync_done_r)) ? 1'b1 :
		(sync_clr ? 1'b0 : sync_occurred_flag);
	assign ist_nxt = lvl[NUM_DI+2:3];

	always_ff @(posedge clock) begin
		if (reset) begin
			st_r                <= GCL_ST_CLOSED;
			hw_r                <= 1'b0;
			count_r             <= 32'sh0000_0000;
			latched_count_value <= 32'sh0000_0000;
			sync_done_r         <= 1'b0;
			cap_done_r          <= 1'b0;
			sync_occurred_flag  <= 1'b0;
			input_state_r       <= '0;
		end else begin
			st_r                <= st_nxt;
			hw_r                <= hw_nxt;
			count_r             <= count_nxt;
			latched_count_value <= cap_nxt;
			sync_done_r         <= sync_done_nxt;
			cap_done_r          <= cap_done_nxt;
			sync_occurred_flag  <= sflag_nxt;
			input_state_r       <= ist_nxt;
		end
	end

	// limit ordering and start range checks
	logic lim_bad, start_bad;
	assign lim_bad   = !(hi > lo);
	assign start_bad = (st > hi) || (st < lo);
	assign status = {22'h00_0000, dup[0], start_bad, lim_bad,
		5'(input_state_r), st_r == GCL_ST_HALTED, sync_occurred_flag};

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_cap_once_hold: assert property (
		cap_once && cap_done_r |=> $stable(latched_count_value))
		else $error("capture changed in once mode");
	a_cap_periodic: assert property (
		!cap_once && cap_ev |=> latched_count_value == $past(count_r))
		else $error("periodic capture missed");
	a_stop_halt: assert property (
		st_r == GCL_ST_OPEN && ext_open && viol && stop_v
		|=> st_r == GCL_ST_HALTED ##1 (st_r != GCL_ST_OPEN))
		else $error("no halt on violation");
	a_wrap_opp: assert property (
		viol && !stop_v && !rld_st && !sync_ev && !(cap_ev && cap_rld)
		&& inc |=> count_r == $past(lo))
		else $error("wrap not to opposite limit");
	a_gate_load: assert property (
		st_r == GCL_ST_CLOSED && ext_open && gstart_ld && !sync_ev
		&& !(cap_ev && cap_rld) |=> count_r == $past(st))
		else $error("gate start load missing");
	a_sync_load: assert property (
		sync_ev && (sync_per || !sync_done_r)
		|=> count_r == $past(st) && sync_occurred_flag)
		else $error("sync load missing");
	a_closed_hold: assert property (
		st_r != GCL_ST_OPEN && !sync_ev && !cap_ev && !ext_open
		|=> $stable(count_r))
		else $error("count moved with gate closed");
	a_in_state: assert property (
		##1 input_state_r == $past(lvl[NUM_DI+2:3]))
		else $error("input state stale");
	c_wrap: cover property (viol && !stop_v);
	c_halt: cover property (st_r == GCL_ST_HALTED);
	c_capt: cover property (cap_ev ##[1:20] cap_ev);
	c_sync: cover property (n_sync_ev);
endmodule // gcl_counter

// file: gcl_counter_tb.sv
// Purpose: self-checking bench for the gated limit counter
// Assumes: pins come from gcl_enc_model, registers over APB
// Notes:   expected counts come from the nxt model below
module gcl_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic               clock = 1'b0;
	logic               reset;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [11:0]        paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready, pslverr, sync_occurred_flag;
	logic               enc_a, enc_b, enc_n, last_err, rld_st;
	logic [2:0]         din, input_state_r, v;
	logic signed [31:0] count_r, latched_count_value;
	logic [31:0]        rdv, hi_v, lo_v, st_v, ex, nv;
	logic [31:0]        seed = 32'h0000_99AB;
	int                 err_count = 0;
	int                 n_compared = 0;

	always #2 clock = ~clock;

	gcl_counter #(.NUM_DI(3)) i_gcl_counter (
		.clock(clock), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
		.enc_n(enc_n), .din(din), .count_r(count_r),
		.latched_count_value(latched_count_value),
		.sync_occurred_flag(sync_occurred_flag),
		.input_state_r(input_state_r)
	);

	gcl_enc_model i_gcl_enc_model (
		.clock(clock), .enc_a(enc_a), .enc_b(enc_b),
		.enc_n(enc_n), .din(din)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Limit crossing reloads instead of stepping past
	function automatic logic [31:0] nxt(input logic [31:0] c,
			input logic up);
		if (up && c == hi_v)
			return rld_st ? st_v : lo_v;
		if (!up && c == lo_v)
			return rld_st ? st_v : hi_v;
		return up ? c + 32'h1 : c - 32'h1;
	endfunction

	task automatic give_verdict();
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock);
		while (pready !== 1'b1);
		rdv = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask

	task automatic do_reset();
		reset   <= 1'b1;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 12'h000;
		pwdata  <= 32'h0;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		ex = 32'h0;
	endtask

	// Gate closes first, so bit 3 decides the reload on opening
	task automatic cfg(input logic [31:0] c, input logic [31:0] h,
			input logic [31:0] l, input logic [31:0] s,
			input logic [31:0] di);
		hi_v = h;
		lo_v = l;
		st_v = s;
		rld_st = c[2];
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h004, h);
		apb(1'b1, 12'h008, l);
		apb(1'b1, 12'h00C, s);
		apb(1'b1, 12'h010, di);
		apb(1'b1, 12'h000, c);
		if (c[3])
			ex = s;
		repeat (3) @(posedge clock);
	endtask

	task automatic go(input int k, input logic r, input logic up,
			input logic cnt);
		logic d;
		for (int j = 0; j < k; j++) begin
			d = r ? 1'(rnd()) : up;
			i_gcl_enc_model.step(d);
			if (cnt)
				ex = nxt(ex, d);
		end
	endtask

	initial begin
		repeat (50000) @(posedge clock);
		err_count++;
		give_verdict();
	end

	initial begin
		do_reset();
		rchk(12'h000, 32'h0);
		rchk(12'h004, 32'h7FFF_FFFF);
		rchk(12'h008, 32'h8000_0000);
		rchk(12'h00C, 32'h0);
		rchk(12'h020, 32'h0);
		chk({31'h0, last_err}, 32'h1);
		v = 3'(rnd());
		i_gcl_enc_model.set_din(v);
		chk({29'h0, input_state_r}, {29'h0, v});
		i_gcl_enc_model.set_din(3'h0);
		go(3, 1'b0, 1'b1, 1'b0);
		chk(count_r, 32'h0);
		for (int e = 0; e < 3; e++) begin
			cfg(32'h1 | (32'(e) << 4), 32'h7FFF_FFFF,
				32'h8000_0000, 32'h0, 32'h0);
			go(4, 1'b0, 1'b1, 1'b0);
			ex = ex + (32'h1 << e);
			chk(count_r, ex);
		end
		for (int r = 0; r < 2; r++) begin
			cfg(32'h29 | (32'(r) << 2), 32'h5, 32'hFFFF_FFFD,
				32'h1, 32'h0);
			chk(count_r, ex);
			go(12, 1'b0, 1'b1, 1'b1);
			chk(count_r, ex);
			go(14, 1'b0, 1'b0, 1'b1);
			chk(count_r, ex);
			go(30, 1'b1, 1'b0, 1'b1);
			chk(count_r, ex);
		end
		cfg(32'h2B, 32'h5, 32'hFFFF_FFFD, 32'h0, 32'h0);
		go(9, 1'b0, 1'b1, 1'b0);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, rdv[1]}, 32'h1);
		cfg(32'h2B, 32'h5, 32'hFFFF_FFFD, 32'h0, 32'h0);
		go(2, 1'b0, 1'b1, 1'b1);
		chk(count_r, ex);
		cfg(32'h121, 32'h64, 32'hFFFF_FF9C, 32'h3, 32'h0004_0601);
		go(2, 1'b0, 1'b1, 1'b0);
		chk(count_r, ex);
		i_gcl_enc_model.set_din(3'b001);
		go(2, 1'b0, 1'b1, 1'b1);
		chk(count_r, ex);
		i_gcl_enc_model.set_din(3'b011);
		chk(latched_count_value, ex);
		go(3, 1'b0, 1'b0, 1'b1);
		i_gcl_enc_model.set_din(3'b001);
		i_gcl_enc_model.set_din(3'b011);
		chk(latched_count_value, ex);
		i_gcl_enc_model.set_din(3'b111);
		ex = st_v;
		chk(count_r, ex);
		chk({31'h0, sync_occurred_flag}, 32'h1);
		go(1, 1'b0, 1'b1, 1'b1);
		i_gcl_enc_model.set_din(3'b011);
		i_gcl_enc_model.set_din(3'b111);
		ex = st_v;
		chk(count_r, ex);
		cfg(32'h4A1, 32'h64, 32'hFFFF_FF9C, 32'h3, 32'h0004_0601);
		go(4, 1'b0, 1'b1, 1'b1);
		nv = ex;
		i_gcl_enc_model.pulse_n();
		chk(latched_count_value, nv);
		chk(count_r, st_v);
		rchk(12'h01C, nv);
		i_gcl_enc_model.set_din(3'b000);
		do_reset();
		cfg(32'h261, 32'h64, 32'hFFFF_FF9C, 32'h3, 32'h0000_0506);
		go(2, 1'b0, 1'b1, 1'b1);
		nv = ex;
		i_gcl_enc_model.set_din(3'b001);
		chk(latched_count_value, nv);
		go(2, 1'b0, 1'b1, 1'b1);
		i_gcl_enc_model.set_din(3'b000);
		i_gcl_enc_model.set_din(3'b001);
		chk(latched_count_value, nv);
		i_gcl_enc_model.pulse_n();
		chk(count_r, ex);
		i_gcl_enc_model.set_din(3'b011);
		i_gcl_enc_model.pulse_n();
		ex = st_v;
		chk(count_r, ex);
		go(1, 1'b0, 1'b1, 1'b1);
		i_gcl_enc_model.pulse_n();
		chk(count_r, ex);
		rchk(12'h018, ex);
		i_gcl_enc_model.set_din(3'b000);
		cfg(32'h21, 32'h64, 32'hFFFF_FF9C, 32'h3, 32'h0000_0302);
		go(2, 1'b0, 1'b1, 1'b0);
		chk(count_r, ex);
		i_gcl_enc_model.set_din(3'b001);
		go(2, 1'b0, 1'b1, 1'b1);
		chk(count_r, ex);
		i_gcl_enc_model.set_din(3'b011);
		go(2, 1'b0, 1'b1, 1'b0);
		chk(count_r, ex);
		apb(1'b1, 12'h000, 32'h0000_0821);
		apb(1'b1, 12'h010, 32'h0000_0303);
		chk({31'h0, sync_occurred_flag}, 32'h0);
		rchk(12'h014, 32'h0000_020C);
		apb(1'b1, 12'h008, 32'h0000_0064);
		rchk(12'h014, 32'h0000_038C);
		give_verdict();
	end
endmodule // gcl_counter_tb

// file: gcl_enc_model.sv
// Purpose: model of the encoder A/B/N lines and field inputs
// Assumes: the bench changes pins only through these tasks
// Notes:   each change is held 6 clocks, the design needs 3
module gcl_enc_model (
	input  wire logic clock,
	output logic      enc_a,
	output logic      enc_b,
	output logic      enc_n,
	output logic [2:0] din
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		enc_a = 1'b0;
		enc_b = 1'b0;
		enc_n = 1'b0;
		din   = 3'h0;
	end

	// Shorter holds would let the synchroniser merge edges
	task automatic settle();
		repeat (6) @(posedge clock);
	endtask

	// Forward order a leads b: 00 10 11 01
	task automatic step(input logic up);
		@(posedge clock);
		if ((enc_a == enc_b) == up)
			enc_a <= ~enc_a;
		else
			enc_b <= ~enc_b;
		settle();
	endtask

	task automatic pulse_n();
		@(posedge clock);
		enc_n <= 1'b1;
		settle();
		enc_n <= 1'b0;
		settle();
	endtask

	task automatic set_din(input logic [2:0] v);
		@(posedge clock);
		din <= v;
		settle();
	endtask
endmodule // gcl_enc_model

// file: gcl_params.svh
// Purpose: constants for the gated limit counter with capture
// Assumes: 32-bit signed counter, three digital inputs
// Notes:   field positions, reset values and offsets live here; enum encodings in gcl_pkg
// Behaviour
// - Once capture latches only the first capture event, later ones ignored.
// - Periodic capture, the default, latches on every capture event.
// - High limit up to 2^31-1, default that, above low limit.
// - Low limit down to -2^31, default that, below high limit.
// - Start value defaults to 0 and lies within the limits.
// - Stop-on-violation halts counting until a gate closes and reopens.
// - Continue-on-violation, the default, keeps counting from the reload value.
// - Violation reloads start value or opposite limit, opposite by default.
// - Gate opening loads start value or continues, continue by default.
// - Level gate input opens the hardware gate while active.
// - Edge gate start and stop inputs open or close the gate.
// - Sync input loads start value on its edge and sets status.
// - Sync-enable input permits reference-mark sync only while active.
// - Capture input latches the count; reference-mark capture may coexist.
// - Unassigned inputs do nothing but their state stays readable.
// - Single, double and quadruple count evaluation are supported.
// - Sync frequency once or periodic.
// - Each function except none may sit on only one input.
`ifndef GCL_PARAMS_SVH
`define GCL_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define GCL_OFS_CTRL    12'h000
`define GCL_OFS_HIGH    12'h004
`define GCL_OFS_LOW     12'h008
`define GCL_OFS_START   12'h00C
`define GCL_OFS_DICFG   12'h010
`define GCL_OFS_STATUS  12'h014
`define GCL_OFS_COUNT   12'h018
`define GCL_OFS_CAPT    12'h01C

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define GCL_CTL_SWGATE  0
`define GCL_CTL_STOPV   1
`define GCL_CTL_RLDST   2
`define GCL_CTL_GSTART  3
`define GCL_CTL_EVAL    4
`define GCL_CTL_NREACT  6
`define GCL_CTL_SYNCPER 8
`define GCL_CTL_CAPONCE 9
`define GCL_CTL_CAPRLD  10
`define GCL_CTL_SYNCCLR 11

// Per-input config: 8 bits each: func[2:0] edge[4:3] lvl_low[5]
`define GCL_DI_STRIDE   8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define GCL_RST_CTRL    32'h0000_0000
`define GCL_RST_HIGH    32'h7FFF_FFFF
`define GCL_RST_LOW     32'h8000_0000
`define GCL_RST_START   32'h0000_0000
`define GCL_RST_DICFG   32'h0000_0000

`endif

// file: gcl_pkg.sv
// Purpose: types for the gated limit counter
// Assumes: nothing beyond the parameter header
// Notes:   encodings are fixed by software view
package gcl_pkg;
	typedef enum logic [2:0] {
		GCL_FN_NONE    = 3'h0,
		GCL_FN_LVLGATE = 3'h1,
		GCL_FN_GSTART  = 3'h2,
		GCL_FN_GSTOP   = 3'h3,
		GCL_FN_SYNC    = 3'h4,
		GCL_FN_SYNCEN  = 3'h5,
		GCL_FN_CAPT    = 3'h6
	} gcl_func_type;
	typedef enum logic [1:0] {
		GCL_EV_SINGLE = 2'h0,
		GCL_EV_DOUBLE = 2'h1,
		GCL_EV_QUAD   = 2'h2
	} gcl_eval_type;
	typedef enum logic [1:0] {
		GCL_N_NONE = 2'h0,
		GCL_N_SYNC = 2'h1,
		GCL_N_CAPT = 2'h2
	} gcl_nreact_type;
	typedef enum logic [1:0] {
		GCL_ED_RISE = 2'h0,
		GCL_ED_FALL = 2'h1,
		GCL_ED_BOTH = 2'h2
	} gcl_edge_type;
	// Gray ordered closed -> open -> halted; halted -> closed changes both bits
	typedef enum logic [1:0] {
		GCL_ST_CLOSED = 2'b00,
		GCL_ST_OPEN   = 2'b01,
		GCL_ST_HALTED = 2'b11
	} gcl_state_type;
endpackage

// file: gcl_sync.sv
// Purpose: two-flop synchroniser with edge detect, one per pin
// Assumes: pins are asynchronous to clock
// Notes:   edges taken from second and third stage only
module gcl_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign level = s2_r;
	assign rise  = s2_r & ~s3_r;
	assign fall  = ~s2_r & s3_r;
endmodule // gcl_sync
